// ==== rtl/gtu_pkg.sv ====
// Constants, register map and field layouts of the general timer unit
package gtu_pkg;
    // Timer indices inside the group
    localparam int NUM_T = 3;
    localparam int IDX_LOW = 0;
    localparam int IDX_CORE = 1;
    localparam int IDX_HIGH = 2;
    localparam int CNT_W = 16;
    // Register port and map (word addresses)
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_CTRL_LOW = 4'h0;
    localparam logic [3:0] OFS_CTRL_CORE = 4'h1;
    localparam logic [3:0] OFS_CTRL_HIGH = 4'h2;
    localparam logic [3:0] OFS_CNT_LOW = 4'h3;
    localparam logic [3:0] OFS_CNT_CORE = 4'h4;
    localparam logic [3:0] OFS_CNT_HIGH = 4'h5;
    localparam logic [3:0] OFS_PRESC = 4'h6;
    localparam logic [3:0] OFS_STATUS = 4'h7;
    localparam logic [3:0] OFS_MASK = 4'h8;
    localparam logic [3:0] OFS_LATCH = 4'h9;
    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [2:0] PRESC_RST = 3'h0;
    localparam logic [3:0] STAT_RST = 4'h0;
    localparam logic LATCH_RST = 1'b0;
    // Prescaler: finest rate is one count per BASE_DIV system clocks
    localparam int PRESC_W = 3;
    localparam int PS_W = 10;
    localparam int BASE_DIV = 4;
    localparam logic [9:0] BASE_MASK = 10'h003;
    // Status bit positions: wraps at 0..2, capture at 3
    localparam int STAT_W = 4;
    localparam int STAT_CAPT = 3;
    // Roles of the low auxiliary timer
    localparam logic [1:0] ROLE_NORMAL = 2'h0;
    localparam logic [1:0] ROLE_RELOAD = 2'h1;
    localparam logic [1:0] ROLE_CAPTURE = 2'h2;
    // Reload trigger selections
    localparam logic [1:0] RLD_PIN = 2'h0;
    localparam logic [1:0] RLD_RISE = 2'h1;
    localparam logic [1:0] RLD_FALL = 2'h2;
    localparam logic [1:0] RLD_ANY = 2'h3;

    typedef enum logic [1:0] {
        MODE_TIMER,
        MODE_GATED,
        MODE_COUNTER,
        MODE_INCR
    } gtu_mode_t;

    // Per-timer control word, bit 0 is the mode field LSB
    typedef struct packed {
        logic spare;
        logic out_en;
        logic [1:0] reload_trig;
        logic [1:0] role;
        logic chain;
        logic src_latch;
        logic [1:0] edge_sel;
        logic gate_high;
        logic dir_ext;
        logic dir_down;
        logic run;
        gtu_mode_t mode;
    } gtu_ctrl_t;
endpackage

// ==== rtl/gtu_timer_group.sv ====
// Three-timer up/down counter group with toggle latch, capture and reload
`timescale 1ns/1ps
// Notes on behaviour
// - Three independent 16-bit up/down timers: low, core and high.
// - Each timer runs as timer, gated timer or counter; low and core also as encoder interface.
// - Timer mode counts on the prescaled system clock tick.
// - Counter mode counts on selected edges of an external or internal source.
// - Gated mode counts prescaled ticks only while the gate level allows.
// - Fastest count rate is one count per four system clocks.
// - Direction set by software or, when enabled, by the direction pin.
// - Encoder mode decodes tracks A and B into count and direction.
// - Core toggle latch inverts on every core overflow or underflow unless software writes the latch in the same cycle.
// - Toggle latch state can be driven onto its output pin.
// - Auxiliary timers can count toggle latch transitions.
// - Low timer can act as capture or reload register and then stops.
// - Capture copies the core count into the low timer on a pin edge.
// - Reload loads core from low timer on pin edge or latch transition.
// - Any timer can count wraps of another, forming a longer count.
// - The high timer has no pins; its sources are internal only.
module gtu_timer_group (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic [gtu_pkg::ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [15:0] o_rdata,
    input wire logic [1:0] i_timer_gate_count_input,
    input wire logic [1:0] i_timer_direction_input,
    output logic o_toggle_latch_output_pin,
    output logic o_irq
);
    gtu_pkg::gtu_ctrl_t ctrl [gtu_pkg::NUM_T];
    logic [15:0] cnt [gtu_pkg::NUM_T];
    logic [gtu_pkg::PRESC_W-1:0] presc;
    logic [gtu_pkg::STAT_W-1:0] status;
    logic [gtu_pkg::STAT_W-1:0] mask;
    logic latch;
    logic latch_prev;
    logic [gtu_pkg::PS_W-1:0] ps_cnt;
    logic [gtu_pkg::PS_W-1:0] ps_mask;
    logic base_tick;
    logic pre_tick;
    logic [1:0] g_meta, g_sync, d_meta, d_sync;
    logic [1:0] g_smp, g_prev, d_smp, d_prev;
    logic smp_new;
    logic [2:0] g_now, g_old, d_now;
    logic [2:0] pin_edge, en, dn, wrap, wrap_q, ovr, cnt_wr;
    logic latch_edge_rise, latch_edge_fall;
    logic latch_rise, latch_fall;
    logic capt_evt, reload_evt;
    logic wr_latch;

    // Free-running prescaler counter
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ps_cnt <= '0;
        end else begin
            ps_cnt <= ps_cnt + 10'h001;
        end
    end

    // Tick masks; the fastest setting still divides by four at least
    // minimum division four
    assign ps_mask = gtu_pkg::PS_W'((gtu_pkg::BASE_DIV << presc) - 1);
    assign base_tick = (ps_cnt & gtu_pkg::BASE_MASK) == gtu_pkg::BASE_MASK;
    assign pre_tick = (ps_cnt & ps_mask) == ps_mask;

    // Two-stage synchronisers for the pins
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            g_meta <= 2'h0;
            g_sync <= 2'h0;
            d_meta <= 2'h0;
            d_sync <= 2'h0;
        end else begin
            g_meta <= i_timer_gate_count_input;
            g_sync <= g_meta;
            d_meta <= i_timer_direction_input;
            d_sync <= d_meta;
        end
    end

    // Pin sampling once per resolution period
    // inputs held one period are seen
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            g_smp <= 2'h0;
            g_prev <= 2'h0;
            d_smp <= 2'h0;
            d_prev <= 2'h0;
            smp_new <= 1'b0;
        end else begin
            smp_new <= base_tick;
            if (base_tick) begin
                g_smp <= g_sync;
                g_prev <= g_smp;
                d_smp <= d_sync;
                d_prev <= d_smp;
            end
        end
    end

    // Toggle latch transitions seen by the counting logic
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            latch_prev <= gtu_pkg::LATCH_RST;
        end else begin
            latch_prev <= latch;
        end
    end
    assign latch_edge_rise = latch & ~latch_prev;
    assign latch_edge_fall = ~latch & latch_prev;

    // Source selection per timer; the high timer only sees internal signals
    // high timer internal sources
    assign g_now = {latch, g_smp};
    assign g_old = {latch_prev, g_prev};
    assign d_now = {1'b0, d_smp};

    // Count enable and direction for each timer
    // four modes for low and core; encoder mode never counts on the high timer
    always_comb begin
        for (int i = 0; i < gtu_pkg::NUM_T; i++) begin
            pin_edge[i] = smp_new && i != gtu_pkg::IDX_HIGH &&
                ((ctrl[i].edge_sel[0] && g_now[i] && !g_old[i]) ||
                 (ctrl[i].edge_sel[1] && !g_now[i] && g_old[i]));
            dn[i] = (ctrl[i].dir_ext && i != gtu_pkg::IDX_HIGH) ? d_now[i] : ctrl[i].dir_down;
            en[i] = 1'b0;
            case (ctrl[i].mode)
                gtu_pkg::MODE_TIMER: begin
                    en[i] = pre_tick;
                end
                gtu_pkg::MODE_GATED: begin
                    en[i] = pre_tick && (g_now[i] == ctrl[i].gate_high);
                end
                gtu_pkg::MODE_COUNTER: begin
                    if (ctrl[i].chain) begin
                        en[i] = (i == gtu_pkg::IDX_CORE) ? wrap_q[gtu_pkg::IDX_LOW] :
                            wrap_q[gtu_pkg::IDX_CORE];
                    end else if (ctrl[i].src_latch && i != gtu_pkg::IDX_CORE) begin
                        en[i] = (ctrl[i].edge_sel[0] && latch_edge_rise) ||
                            (ctrl[i].edge_sel[1] && latch_edge_fall);
                    end else begin
                        en[i] = pin_edge[i];
                    end
                end
                gtu_pkg::MODE_INCR: begin
                    // quadrature decode of tracks A and B
                    en[i] = smp_new && i != gtu_pkg::IDX_HIGH &&
                        ((g_now[i] != g_old[i]) || (d_smp[i[0]] != d_prev[i[0]]));
                    dn[i] = ctrl[i].dir_down ^ ~(g_old[i] ^ d_now[i]);
                end
                default: begin
                    en[i] = 1'b0;
                end
            endcase
            en[i] = en[i] && ctrl[i].run;
        end
        // low timer stopped while capture or reload
        if (ctrl[gtu_pkg::IDX_LOW].role != gtu_pkg::ROLE_NORMAL) begin
            en[gtu_pkg::IDX_LOW] = 1'b0;
        end
    end

    // Capture and reload triggers
    assign latch_rise = wrap[gtu_pkg::IDX_CORE] & ~latch & ~wr_latch;
    assign latch_fall = wrap[gtu_pkg::IDX_CORE] & latch & ~wr_latch;
    assign capt_evt = ctrl[gtu_pkg::IDX_LOW].role == gtu_pkg::ROLE_CAPTURE &&
        pin_edge[gtu_pkg::IDX_LOW];
    always_comb begin
        reload_evt = 1'b0;
        if (ctrl[gtu_pkg::IDX_LOW].role == gtu_pkg::ROLE_RELOAD) begin
            case (ctrl[gtu_pkg::IDX_LOW].reload_trig)
                gtu_pkg::RLD_PIN: reload_evt = pin_edge[gtu_pkg::IDX_LOW];
                gtu_pkg::RLD_RISE: reload_evt = latch_rise;
                gtu_pkg::RLD_FALL: reload_evt = latch_fall;
                gtu_pkg::RLD_ANY: reload_evt = latch_rise | latch_fall;
                default: reload_evt = 1'b0;
            endcase
        end
    end

    // Software writes to the count registers
    always_comb begin
        for (int i = 0; i < gtu_pkg::NUM_T; i++) begin
            cnt_wr[i] = i_write && i_addr == gtu_pkg::ADDR_W'(gtu_pkg::OFS_CNT_LOW + i);
        end
    end

    // Wrap on a real count; a count write wins, a reload does not
    // Kept free of reload_evt, which itself depends on the core wrap
    // wrap detection at both ends
    always_comb begin
        for (int i = 0; i < gtu_pkg::NUM_T; i++) begin
            wrap[i] = en[i] && !cnt_wr[i] &&
                (dn[i] ? cnt[i] == 16'h0000 : cnt[i] == 16'hffff);
        end
    end

    // Every source that replaces the count in this cycle
    assign ovr = cnt_wr | {1'b0, reload_evt, capt_evt};

    // Count registers
    // three 16-bit up/down counters
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int i = 0; i < gtu_pkg::NUM_T; i++) begin
                cnt[i] <= gtu_pkg::CNT_RST;
            end
            wrap_q <= 3'h0;
        end else begin
            wrap_q <= wrap;
            for (int i = 0; i < gtu_pkg::NUM_T; i++) begin
                if (i_write && i_addr == gtu_pkg::ADDR_W'(gtu_pkg::OFS_CNT_LOW + i)) begin
                    cnt[i] <= i_wdata;
                end else if (i == gtu_pkg::IDX_LOW && capt_evt) begin
                    cnt[i] <= cnt[gtu_pkg::IDX_CORE];
                end else if (i == gtu_pkg::IDX_CORE && reload_evt) begin
                    cnt[i] <= cnt[gtu_pkg::IDX_LOW];
                end else if (en[i]) begin
                    cnt[i] <= dn[i] ? cnt[i] - 16'h0001 : cnt[i] + 16'h0001;
                end
            end
        end
    end

    // Toggle latch; software may preset it
    assign wr_latch = i_write && i_addr == gtu_pkg::OFS_LATCH;
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            latch <= gtu_pkg::LATCH_RST;
        end else if (wr_latch) begin
            latch <= i_wdata[0];
        end else if (wrap[gtu_pkg::IDX_CORE]) begin
            latch <= ~latch;
        end
    end

    // Registered latch pin
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_toggle_latch_output_pin <= 1'b0;
        end else begin
            o_toggle_latch_output_pin <= latch & ctrl[gtu_pkg::IDX_CORE].out_en;
        end
    end

    // Control, prescaler and mask registers
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int i = 0; i < gtu_pkg::NUM_T; i++) begin
                ctrl[i] <= gtu_pkg::CTRL_RST;
            end
            presc <= gtu_pkg::PRESC_RST;
            mask <= gtu_pkg::STAT_RST;
        end else if (i_write) begin
            for (int i = 0; i < gtu_pkg::NUM_T; i++) begin
                if (i_addr == gtu_pkg::ADDR_W'(gtu_pkg::OFS_CTRL_LOW + i)) begin
                    ctrl[i] <= i_wdata;
                end
            end
            if (i_addr == gtu_pkg::OFS_PRESC) begin
                presc <= i_wdata[gtu_pkg::PRESC_W-1:0];
            end
            if (i_addr == gtu_pkg::OFS_MASK) begin
                mask <= i_wdata[gtu_pkg::STAT_W-1:0];
            end
        end
    end

    // Sticky status, write one to clear, a new event wins over the clear
    // wrap raises a request flag
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            status <= gtu_pkg::STAT_RST;
        end else begin
            status <= (status & ~((i_write && i_addr == gtu_pkg::OFS_STATUS) ?
                i_wdata[gtu_pkg::STAT_W-1:0] : 4'h0)) | {capt_evt, wrap};
        end
    end
    assign o_irq = |(status & mask);

    // Read data, valid the cycle after the strobe
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 16'h0000;
        end else if (i_read) begin
            case (i_addr)
                gtu_pkg::OFS_CTRL_LOW: o_rdata <= ctrl[gtu_pkg::IDX_LOW];
                gtu_pkg::OFS_CTRL_CORE: o_rdata <= ctrl[gtu_pkg::IDX_CORE];
                gtu_pkg::OFS_CTRL_HIGH: o_rdata <= ctrl[gtu_pkg::IDX_HIGH];
                gtu_pkg::OFS_CNT_LOW: o_rdata <= cnt[gtu_pkg::IDX_LOW];
                gtu_pkg::OFS_CNT_CORE: o_rdata <= cnt[gtu_pkg::IDX_CORE];
                gtu_pkg::OFS_CNT_HIGH: o_rdata <= cnt[gtu_pkg::IDX_HIGH];
                gtu_pkg::OFS_PRESC: o_rdata <= {13'h0000, presc};
                gtu_pkg::OFS_STATUS: o_rdata <= {12'h000, status};
                gtu_pkg::OFS_MASK: o_rdata <= {12'h000, mask};
                gtu_pkg::OFS_LATCH: o_rdata <= {15'h0000, latch};
                default: o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    // Checks on the timing and data paths
    AST_BASE_SPACING: assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        base_tick |=> !base_tick [*3])
        else $error("Resolution tick faster than four clocks");

    AST_TIMER_TICK_ONLY: assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        (ctrl[gtu_pkg::IDX_HIGH].mode == gtu_pkg::MODE_TIMER && !pre_tick && !ovr[2])
        |=> $stable(cnt[gtu_pkg::IDX_HIGH]))
        else $error("Timer mode counted without a prescaler tick");

    AST_CORE_WRAP_UP: assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        (en[1] && !dn[1] && !ovr[1] && cnt[1] == 16'hffff)
        |=> cnt[1] == 16'h0000 && status[gtu_pkg::IDX_CORE])
        else $error("Core up wrap or its flag missing");

    AST_LATCH_TOGGLE: assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        (wrap[gtu_pkg::IDX_CORE] && !wr_latch) |=> latch != $past(latch))
        else $error("Toggle latch did not invert on core wrap");

    AST_PIN_FOLLOWS: assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        ##1 o_toggle_latch_output_pin == $past(latch & ctrl[gtu_pkg::IDX_CORE].out_en))
        else $error("Latch pin does not follow latch");

    AST_CAPTURE: assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        (capt_evt && !(i_write && i_addr == gtu_pkg::OFS_CNT_LOW))
        |=> cnt[gtu_pkg::IDX_LOW] == $past(cnt[gtu_pkg::IDX_CORE]) && status[gtu_pkg::STAT_CAPT])
        else $error("Capture did not copy core count");

    AST_RELOAD: assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        (reload_evt && !(i_write && i_addr == gtu_pkg::OFS_CNT_CORE))
        |=> cnt[gtu_pkg::IDX_CORE] == $past(cnt[gtu_pkg::IDX_LOW]))
        else $error("Reload did not load core");

    AST_LOW_STOPPED: assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        (ctrl[gtu_pkg::IDX_LOW].role != gtu_pkg::ROLE_NORMAL && !ovr[gtu_pkg::IDX_LOW])
        |=> $stable(cnt[gtu_pkg::IDX_LOW]))
        else $error("Low timer counted in capture or reload role");

    AST_READ_LATENCY: assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        (i_read && i_addr == gtu_pkg::OFS_CNT_HIGH) |=> o_rdata == $past(cnt[2]))
        else $error("Count read returned wrong value");

    AST_GATE_CLOSED: assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        (ctrl[gtu_pkg::IDX_CORE].mode == gtu_pkg::MODE_GATED &&
            g_now[gtu_pkg::IDX_CORE] != ctrl[gtu_pkg::IDX_CORE].gate_high && !ovr[1])
        |=> $stable(cnt[gtu_pkg::IDX_CORE]))
        else $error("Gated core counted with its gate closed");

    AST_HIGH_SW_DIR: assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        (ctrl[gtu_pkg::IDX_HIGH].mode != gtu_pkg::MODE_INCR)
        |-> dn[gtu_pkg::IDX_HIGH] == ctrl[gtu_pkg::IDX_HIGH].dir_down)
        else $error("High timer direction taken from a pin");
endmodule

// ==== testbench/gtu_pin_model.sv ====
// Far-side pin model driving gate, count, direction and encoder tracks
`timescale 1ns/1ps
module gtu_pin_model (
    input wire logic i_clock,
    output logic [1:0] o_gate,
    output logic [1:0] o_dir
);
    // Pins idle low until a scenario moves them
    initial begin
        o_gate = 2'h0;
        o_dir = 2'h0;
    end

    task automatic hold();
        repeat (4 + $urandom % 5) @(posedge i_clock);
    endtask

    // Gate or count pin level
    task automatic set_gate(input int idx, input logic v);
        o_gate[idx] <= v;
        hold();
    endtask

    // Direction pin level
    task automatic set_dir(input int idx, input logic v);
        o_dir[idx] <= v;
        hold();
    endtask

    // Full count pulses, rising then falling
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            set_gate(idx, 1'b1);
            set_gate(idx, 1'b0);
        end
    endtask

    // Four quadrature steps on the core tracks
    task automatic quad(input bit up);
        logic [7:0] s;
        s = up ? 8'h78 : 8'hb4;
        for (int k = 0; k < 4; k++) begin
            o_gate[1] <= s[7 - 2 * k];
            o_dir[1] <= s[6 - 2 * k];
            hold();
        end
    endtask
endmodule

// ==== testbench/tb_gtu_timer_group.sv ====
// Self-checking bench of the three-timer group
`timescale 1ns/1ps
`define GTU_CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module tb_gtu_timer_group;
    typedef struct packed {
        logic [1:0] kind;
        logic [15:0] val;
    } gtu_exp_t;
    logic i_clock, i_arst_n, i_write, i_read, o_pin, o_irq;
    logic [gtu_pkg::ADDR_W-1:0] i_addr;
    logic [15:0] i_wdata, o_rdata, r;
    logic [15:0] last_rd = 16'h0000;
    logic [1:0] pin_gate, pin_dir;
    logic rd_seen = 1'b0;
    logic chk_req = 1'b0;
    int num_errors = 0;
    int samples_checked = 0;
    gtu_exp_t exp_q[$];
    gtu_exp_t cur;

    gtu_timer_group u_dut (
        .i_clock(i_clock), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
        .i_timer_gate_count_input(pin_gate), .i_timer_direction_input(pin_dir),
        .o_toggle_latch_output_pin(o_pin), .o_irq(o_irq)
    );
    gtu_pin_model u_pins (.i_clock(i_clock), .o_gate(pin_gate), .o_dir(pin_dir));

    // System clock, 100 ns period
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    // Answers against the oldest note: absolute, delta, record only or pins
    always @(negedge i_clock) begin
        if ((rd_seen || chk_req) && exp_q.size() > 0) begin
            cur = exp_q.pop_front();
            if (cur.kind == 2'h0) `GTU_CHK(o_rdata, cur.val)
            else if (cur.kind == 2'h1) `GTU_CHK(16'(o_rdata - last_rd), cur.val)
            else if (cur.kind == 2'h3) `GTU_CHK({14'h0000, o_irq, o_pin}, cur.val)
            if (cur.kind != 2'h3) begin
                last_rd = o_rdata;
            end
        end
        rd_seen <= i_read;
    end

    task automatic give_verdict();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge i_clock);
    endtask

    // One-cycle register write
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask

    // One-cycle register read, note filed first
    task automatic rd(input logic [3:0] a, input logic [15:0] v, input logic [1:0] k);
        exp_q.push_back('{kind: k, val: v});
        @(posedge i_clock);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
    endtask

    // Interrupt and latch pin levels, looked at mid-cycle by the monitor
    task automatic chk_out(input logic [1:0] v);
        @(posedge i_clock);
        exp_q.push_back('{kind: 2'h3, val: {14'h0000, v}});
        chk_req <= 1'b1;
        @(posedge i_clock);
        chk_req <= 1'b0;
    endtask

    // Two reads 400 clocks apart, any prescaler phase gives an exact delta
    task automatic span(input logic [3:0] a, input logic [15:0] v);
        rd(a, 16'h0000, 2'h2);
        idle(398);
        rd(a, v, 2'h1);
    endtask

    // Hang guard
    initial begin
        idle(20000);
        num_errors++;
        give_verdict();
    end

    // Main sequence
    initial begin
        i_arst_n = 1'b0;
        i_addr = '0;
        i_wdata = 16'h0000;
        i_write = 1'b0;
        i_read = 1'b0;
        void'($urandom(32'h206cbb44));
        idle(20);
        i_arst_n <= 1'b1;
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0], 16'h0000, 2'h0);
        end
        r = 16'($urandom);
        wr(gtu_pkg::OFS_CNT_LOW, r);
        rd(gtu_pkg::OFS_CNT_LOW, r, 2'h0);
        wr(4'ha, r);
        rd(4'ha, 16'h0000, 2'h0);
        wr(gtu_pkg::OFS_MASK, 16'hffff);
        rd(gtu_pkg::OFS_MASK, 16'h000f, 2'h0);
        wr(gtu_pkg::OFS_MASK, 16'h0000);
        for (int p = 0; p < 3; p++) begin
            wr(gtu_pkg::OFS_PRESC, 16'(p));
            wr(gtu_pkg::OFS_CNT_CORE, 16'h8000);
            wr(gtu_pkg::OFS_CTRL_CORE, 16'h0004);
            span(gtu_pkg::OFS_CNT_CORE, 16'(100 >> p));
        end
        wr(gtu_pkg::OFS_PRESC, 16'h0000);
        wr(gtu_pkg::OFS_CTRL_CORE, 16'h000c);
        span(gtu_pkg::OFS_CNT_CORE, 16'hff9c);
        // Gated core: counts only while its gate pin is high
        wr(gtu_pkg::OFS_CTRL_CORE, 16'h0025);
        u_pins.set_gate(1, 1'b1);
        idle(12);
        span(gtu_pkg::OFS_CNT_CORE, 16'd100);
        u_pins.set_gate(1, 1'b0);
        idle(12);
        span(gtu_pkg::OFS_CNT_CORE, 16'h0000);
        // Encoder core: four steps each way
        wr(gtu_pkg::OFS_CTRL_CORE, 16'h0000);
        wr(gtu_pkg::OFS_CNT_CORE, 16'h0100);
        wr(gtu_pkg::OFS_CTRL_CORE, 16'h0007);
        u_pins.quad(1'b1);
        idle(12);
        rd(gtu_pkg::OFS_CNT_CORE, 16'h0104, 2'h0);
        u_pins.quad(1'b0);
        idle(12);
        rd(gtu_pkg::OFS_CNT_CORE, 16'h0100, 2'h0);
        // Low counter on rising pin edges, direction from its pin
        wr(gtu_pkg::OFS_CNT_LOW, 16'h0010);
        wr(gtu_pkg::OFS_CTRL_LOW, 16'h0056);
        u_pins.pulse(0, 5);
        idle(12);
        rd(gtu_pkg::OFS_CNT_LOW, 16'h0015, 2'h0);
        u_pins.set_dir(0, 1'b1);
        u_pins.pulse(0, 3);
        idle(12);
        rd(gtu_pkg::OFS_CNT_LOW, 16'h0012, 2'h0);
        // Capture then reload through the low timer
        wr(gtu_pkg::OFS_CTRL_CORE, 16'h0000);
        wr(gtu_pkg::OFS_CNT_CORE, 16'h1234);
        wr(gtu_pkg::OFS_STATUS, 16'h000f);
        wr(gtu_pkg::OFS_CTRL_LOW, 16'h0840);
        u_pins.pulse(0, 1);
        idle(12);
        rd(gtu_pkg::OFS_CNT_LOW, 16'h1234, 2'h0);
        rd(gtu_pkg::OFS_STATUS, 16'h0008, 2'h0);
        wr(gtu_pkg::OFS_CNT_LOW, 16'h5a5a);
        wr(gtu_pkg::OFS_CTRL_LOW, 16'h0440);
        u_pins.pulse(0, 1);
        idle(12);
        rd(gtu_pkg::OFS_CNT_CORE, 16'h5a5a, 2'h0);
        rd(gtu_pkg::OFS_CNT_LOW, 16'h5a5a, 2'h0);
        // Core wrap: flag, latch, pin, chained high timer, interrupt
        wr(gtu_pkg::OFS_CTRL_LOW, 16'h0000);
        wr(gtu_pkg::OFS_CTRL_HIGH, 16'h0206);
        wr(gtu_pkg::OFS_STATUS, 16'h000f);
        wr(gtu_pkg::OFS_CNT_CORE, 16'hfffe);
        wr(gtu_pkg::OFS_CTRL_CORE, 16'h4004);
        idle(30);
        wr(gtu_pkg::OFS_CTRL_CORE, 16'h4000);
        chk_out(2'h1);
        rd(gtu_pkg::OFS_STATUS, 16'h0002, 2'h0);
        rd(gtu_pkg::OFS_LATCH, 16'h0001, 2'h0);
        rd(gtu_pkg::OFS_CNT_HIGH, 16'h0001, 2'h0);
        chk_out(2'h1);
        wr(gtu_pkg::OFS_MASK, 16'h0002);
        idle(2);
        chk_out(2'h3);
        wr(gtu_pkg::OFS_STATUS, 16'h0002);
        idle(2);
        chk_out(2'h1);
        // High timer counts latch transitions
        wr(gtu_pkg::OFS_CTRL_HIGH, 16'h01c6);
        wr(gtu_pkg::OFS_LATCH, 16'h0000);
        wr(gtu_pkg::OFS_LATCH, 16'h0001);
        idle(4);
        rd(gtu_pkg::OFS_CNT_HIGH, 16'h0003, 2'h0);
        // Core reload from the low timer on a latch rise, replacing the wrap
        wr(gtu_pkg::OFS_LATCH, 16'h0000);
        wr(gtu_pkg::OFS_CNT_LOW, r);
        wr(gtu_pkg::OFS_CTRL_LOW, 16'h1400);
        wr(gtu_pkg::OFS_CNT_CORE, 16'hffff);
        wr(gtu_pkg::OFS_CTRL_CORE, 16'h0046);
        u_pins.pulse(1, 1);
        idle(12);
        rd(gtu_pkg::OFS_CNT_CORE, r, 2'h0);
        rd(gtu_pkg::OFS_LATCH, 16'h0001, 2'h0);
        // Second reset in mid-run
        @(posedge i_clock);
        i_arst_n <= 1'b0;
        idle(3);
        i_arst_n <= 1'b1;
        rd(gtu_pkg::OFS_CTRL_HIGH, 16'h0000, 2'h0);
        rd(gtu_pkg::OFS_LATCH, 16'h0000, 2'h0);
        chk_out(2'h0);
        idle(2);
        give_verdict();
    end
endmodule
